// file: rtl/ipta_pkg.sv
package ipta_pkg;

  // ---------------------------------------------
  // source and trap counts
  // ---------------------------------------------
  localparam int NUM_SRC = 54;
  localparam int NUM_TRAP = 8;
  localparam int PRIO_W = 3;
  localparam int SLOT_W = 4;
  localparam int SLOTS_PER_REG = 4;
  localparam int NUM_PRIO_REG = 14;

  // interrupt numbers that carry a real source
  localparam logic [63:0] SRC_IMPL_MASK = 64'h0000_0990_0087_FFFF;

  // vector = interrupt number + base; trap vector = trap index + base
  localparam logic [7:0] IRQ_VEC_BASE = 8'h08;
  localparam logic [7:0] TRAP_VEC_BASE = 8'h00;
  localparam logic [3:0] TRAP_LVL_BASE = 4'h8;
  localparam logic [2:0] ADDR_ERR_TRAP = 3'h4;

  // program counter value forced by a device reset
  localparam logic [23:0] RESET_PC_VAL = 24'h000000;

  // ---------------------------------------------
  // register byte offsets
  // ---------------------------------------------
  localparam logic [7:0] PRIO_BASE_OFS = 8'h00;
  localparam logic [7:0] FLAG_LO_OFS = 8'h40;
  localparam logic [7:0] FLAG_HI_OFS = 8'h44;
  localparam logic [7:0] EN_LO_OFS = 8'h48;
  localparam logic [7:0] EN_HI_OFS = 8'h4C;
  localparam logic [7:0] STATUS_OFS = 8'h50;
  localparam logic [7:0] CAUSE_OFS = 8'h54;

  // ---------------------------------------------
  // field positions and reset values
  // ---------------------------------------------
  localparam int ST_VEC_LSB = 0;
  localparam int ST_LVL_LSB = 8;
  localparam int ST_VALID_BIT = 12;
  localparam int ST_TRAP_BIT = 13;
  localparam int ST_TPEND_LSB = 16;

  localparam int CAUSE_WDT = 0;
  localparam int CAUSE_UNINIT = 1;
  localparam int CAUSE_ILLEGAL = 2;
  localparam int CAUSE_BROWNOUT = 3;
  localparam int CAUSE_LOCKOUT = 4;
  localparam int CAUSE_W = 5;

  localparam logic [2:0] PRIO_RST = 3'h0;
  localparam logic [31:0] EN_RST = 32'h0000_0000;

  // request presented to the core
  typedef struct packed {
    logic valid;
    logic trap;
    logic [3:0] level;
    logic [7:0] vector;
  } core_req_t;

endpackage

// file: rtl/prio_pick.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------
// highest priority pick, lowest index on a tie
// ---------------------------------------------
module prio_pick #(
  parameter int N = 54,
  parameter int IW = 6
) (
  // candidates
  input wire logic [N-1:0] req,
  input wire logic [3*N-1:0] prio,
  // winner
  output logic found,
  output logic [IW-1:0] idx,
  output logic [2:0] level
);

  // scan downward so an equal level at a lower index replaces the winner
  always_comb begin
    found = 1'b0;
    idx = '0;
    level = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (prio[3*i +: 3] >= level)) begin
        found = 1'b1;
        idx = IW'(i);
        level = prio[3*i +: 3];
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/interrupt_priority_trap_arbiter.sv
`timescale 1ns/1ps
`default_nettype none

module interrupt_priority_trap_arbiter #(
  parameter int NUM_SRC = ipta_pkg::NUM_SRC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // peripheral event pulses, one per interrupt number
  input wire logic [NUM_SRC-1:0] SRC_EVENT,
  // trap events, index i is trap level 8+i
  input wire logic [ipta_pkg::NUM_TRAP-1:0] TRAP_EVENT,
  input wire logic VEC_ADDR_INVALID,
  input wire logic INSTR_DONE,
  // reset causes
  input wire logic WDT_TIMEOUT,
  input wire logic UNINIT_W_PTR,
  input wire logic ILLEGAL_OP_EXEC,
  input wire logic ILLEGAL_OP_FLUSHED,
  input wire logic BROWNOUT,
  // processor core
  input wire logic [3:0] CPU_PRIORITY_LEVEL,
  input wire logic CORE_ACK,
  output var ipta_pkg::core_req_t CORE_REQ,
  output logic TRAP_LEVEL_FLAG,
  output logic RESET_REQ,
  output logic [23:0] RESET_PC
);

  localparam int IW = 6;
  localparam int NT = ipta_pkg::NUM_TRAP;

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  logic [2:0] prio_r [NUM_SRC];
  logic [NUM_SRC-1:0] flag_r;
  logic [NUM_SRC-1:0] flag_nxt;
  logic [NUM_SRC-1:0] en_r;
  logic [NT-1:0] tpend_r;
  logic [NT-1:0] tpend_nxt;
  logic [ipta_pkg::CAUSE_W-1:0] cause_r;
  logic [ipta_pkg::CAUSE_W-1:0] cause_nxt;
  ipta_pkg::core_req_t req_r;
  ipta_pkg::core_req_t req_nxt;
  logic [31:0] prdata_r;
  logic slverr_r;
  logic rst_req_r;
  logic tflag_r;
  logic [23:0] rst_pc_r;

  // ---------------------------------------------
  // apb decode
  // ---------------------------------------------
  wire logic setup_ph = PSEL & ~PENABLE;
  wire logic wr_acc = PSEL & PENABLE & PWRITE;
  wire logic [3:0] prio_idx = PADDR[5:2];
  wire logic word_al = (PADDR[1:0] == 2'b00);
  wire logic hit_prio = word_al && (PADDR[7:6] == 2'b00)
    && (prio_idx < 4'(ipta_pkg::NUM_PRIO_REG));
  wire logic hit_flo = (PADDR == ipta_pkg::FLAG_LO_OFS);
  wire logic hit_fhi = (PADDR == ipta_pkg::FLAG_HI_OFS);
  wire logic hit_elo = (PADDR == ipta_pkg::EN_LO_OFS);
  wire logic hit_ehi = (PADDR == ipta_pkg::EN_HI_OFS);
  wire logic hit_st = (PADDR == ipta_pkg::STATUS_OFS);
  wire logic hit_cause = (PADDR == ipta_pkg::CAUSE_OFS);
  wire logic hit_any = hit_prio | hit_flo | hit_fhi | hit_elo
    | hit_ehi | hit_st | hit_cause;
  wire logic we_prio = wr_acc & hit_prio;
  wire logic we_flo = wr_acc & hit_flo;
  wire logic we_fhi = wr_acc & hit_fhi;
  wire logic we_elo = wr_acc & hit_elo;
  wire logic we_ehi = wr_acc & hit_ehi;
  wire logic we_cause = wr_acc & hit_cause;

  // zero-wait slave: the access phase always completes
  assign PREADY = PENABLE;
  assign PRDATA = prdata_r;
  assign PSLVERR = slverr_r;

  // ---------------------------------------------
  // source masks
  // ---------------------------------------------
  wire logic [NUM_SRC-1:0] impl = ipta_pkg::SRC_IMPL_MASK[NUM_SRC-1:0];
  logic [63:0] flag_w1c;
  logic [63:0] en_wr;
  logic [63:0] flag_64;
  logic [63:0] en_64;

  // software writes ones to clear flags; split over two words
  always_comb begin
    flag_w1c = 64'h0;
    if (we_flo) begin
      flag_w1c[31:0] = PWDATA;
    end
    if (we_fhi) begin
      flag_w1c[63:32] = PWDATA;
    end
  end

  // enable write data, old word kept for the half not written
  always_comb begin
    en_64 = 64'h0;
    en_64[NUM_SRC-1:0] = en_r;
    flag_64 = 64'h0;
    flag_64[NUM_SRC-1:0] = flag_r;
    en_wr = en_64;
    if (we_elo) begin
      en_wr[31:0] = PWDATA;
    end
    if (we_ehi) begin
      en_wr[63:32] = PWDATA;
    end
  end

  // a flag rises on its event whatever its enable; set beats clear
  assign flag_nxt = (flag_r & ~flag_w1c[NUM_SRC-1:0])
    | (SRC_EVENT & impl);

  // ---------------------------------------------
  // priority assignment read data
  // ---------------------------------------------
  logic [15:0] prio_word;

  // bit 3 of every nibble is not stored and reads zero
  always_comb begin
    int s;
    s = 0;
    prio_word = 16'h0;
    for (int j = 0; j < ipta_pkg::SLOTS_PER_REG; j++) begin
      s = int'(prio_idx) * ipta_pkg::SLOTS_PER_REG + j;
      if (s < NUM_SRC) begin
        prio_word[j*ipta_pkg::SLOT_W +: 3] = prio_r[s];
      end
    end
  end

  // ---------------------------------------------
  // interrupt arbitration
  // ---------------------------------------------
  logic [3*NUM_SRC-1:0] prio_flat;
  logic [NUM_SRC-1:0] prio_nz;

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      prio_flat[3*i +: 3] = prio_r[i];
      prio_nz[i] = (prio_r[i] != 3'h0);
    end
  end

  // reserved slots never compete even if software wrote them
  wire logic [NUM_SRC-1:0] cand = flag_r & en_r & impl & prio_nz;
  logic irq_found;
  logic [IW-1:0] irq_idx;
  logic [2:0] irq_lvl;

  prio_pick #(
    .N(NUM_SRC),
    .IW(IW)
  ) u_pick (
    .req(cand),
    .prio(prio_flat),
    .found(irq_found),
    .idx(irq_idx),
    .level(irq_lvl)
  );

  // level 7 or any trap level in the core leaves no interrupt above it
  wire logic irq_go = irq_found
    && ({1'b0, irq_lvl} > CPU_PRIORITY_LEVEL);

  // ---------------------------------------------
  // trap capture and selection
  // ---------------------------------------------
  // a bad trap vector is reported back as an address error trap
  wire logic [NT-1:0] t_new = TRAP_EVENT
    | (NT'(VEC_ADDR_INVALID) << ipta_pkg::ADDR_ERR_TRAP);
  wire logic t_multi = |(t_new & (t_new - NT'(1)));
  wire logic req_is_trap = req_r.valid & req_r.trap;
  wire logic [2:0] ack_tidx = req_r.vector[2:0];
  logic [NT-1:0] t_ack;
  logic t_found;
  logic [2:0] t_idx;

  // clear the served trap on the core's acknowledge
  always_comb begin
    t_ack = '0;
    if (CORE_ACK && req_is_trap) begin
      t_ack[ack_tidx] = 1'b1;
    end
  end

  // several traps at once go to reset instead of being latched
  assign tpend_nxt = (tpend_r & ~t_ack)
    | (t_multi ? '0 : t_new);

  // fixed order: highest trap index is the highest level
  always_comb begin
    t_found = 1'b0;
    t_idx = 3'h0;
    for (int i = 0; i < NT; i++) begin
      if (tpend_r[i]) begin
        t_found = 1'b1;
        t_idx = 3'(i);
      end
    end
  end

  wire logic [3:0] t_lvl = ipta_pkg::TRAP_LVL_BASE + {1'b0, t_idx};
  // traps ignore enables and user priority; a higher one nests
  wire logic t_go = t_found && INSTR_DONE
    && (t_lvl > CPU_PRIORITY_LEVEL);

  // ---------------------------------------------
  // request to the core
  // ---------------------------------------------
  // trap wins over any interrupt since its level is always higher
  always_comb begin
    req_nxt = '0;
    if (t_go) begin
      req_nxt.valid = 1'b1;
      req_nxt.trap = 1'b1;
      req_nxt.level = t_lvl;
      req_nxt.vector = ipta_pkg::TRAP_VEC_BASE + {5'h0, t_idx};
    end else if (irq_go) begin
      req_nxt.valid = 1'b1;
      req_nxt.level = {1'b0, irq_lvl};
      req_nxt.vector = ipta_pkg::IRQ_VEC_BASE + {2'b00, irq_idx};
    end
  end

  // ---------------------------------------------
  // reset causes
  // ---------------------------------------------
  logic [ipta_pkg::CAUSE_W-1:0] cause_ev;

  always_comb begin
    cause_ev = '0;
    cause_ev[ipta_pkg::CAUSE_WDT] = WDT_TIMEOUT;
    cause_ev[ipta_pkg::CAUSE_UNINIT] = UNINIT_W_PTR;
    cause_ev[ipta_pkg::CAUSE_ILLEGAL] = ILLEGAL_OP_EXEC
      & ~ILLEGAL_OP_FLUSHED;
    cause_ev[ipta_pkg::CAUSE_BROWNOUT] = BROWNOUT;
    cause_ev[ipta_pkg::CAUSE_LOCKOUT] = t_multi;
  end

  // sticky cause bits, write one to clear, a new cause wins
  assign cause_nxt = (cause_r & ~(we_cause ? PWDATA[ipta_pkg::CAUSE_W-1:0] : '0))
    | cause_ev;

  // ---------------------------------------------
  // read mux, sampled in the setup phase
  // ---------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0;
    if (hit_prio) begin
      rd_word[15:0] = prio_word;
    end else if (hit_flo) begin
      rd_word = flag_64[31:0];
    end else if (hit_fhi) begin
      rd_word = flag_64[63:32];
    end else if (hit_elo) begin
      rd_word = en_64[31:0];
    end else if (hit_ehi) begin
      rd_word = en_64[63:32];
    end else if (hit_st) begin
      rd_word[ipta_pkg::ST_VEC_LSB +: 8] = req_r.vector;
      rd_word[ipta_pkg::ST_LVL_LSB +: 4] = req_r.level;
      rd_word[ipta_pkg::ST_VALID_BIT] = req_r.valid;
      rd_word[ipta_pkg::ST_TRAP_BIT] = req_r.trap;
      rd_word[ipta_pkg::ST_TPEND_LSB +: NT] = tpend_r;
    end else if (hit_cause) begin
      rd_word[ipta_pkg::CAUSE_W-1:0] = cause_r;
    end
  end

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  // bus answer registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_r <= 32'h0;
      slverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= PWRITE ? 32'h0 : rd_word;
      slverr_r <= ~hit_any;
    end
  end

  // priority slots; only three bits per slot are kept
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        prio_r[i] <= ipta_pkg::PRIO_RST;
      end
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (we_prio && (prio_idx == 4'(i / ipta_pkg::SLOTS_PER_REG))) begin
          prio_r[i] <= PWDATA[(i % ipta_pkg::SLOTS_PER_REG) * ipta_pkg::SLOT_W +: 3];
        end
      end
    end
  end

  // flags, enables, traps and causes
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_r <= '0;
      en_r <= '0;
      tpend_r <= '0;
      cause_r <= '0;
    end else begin
      flag_r <= flag_nxt;
      en_r <= en_wr[NUM_SRC-1:0];
      tpend_r <= tpend_nxt;
      cause_r <= cause_nxt;
    end
  end

  // core side outputs; reset itself never runs through arbitration
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      req_r <= '0;
      tflag_r <= 1'b0;
      rst_req_r <= 1'b0;
      rst_pc_r <= ipta_pkg::RESET_PC_VAL;
    end else begin
      req_r <= req_nxt;
      tflag_r <= req_nxt.valid & req_nxt.trap;
      rst_req_r <= |cause_ev;
      rst_pc_r <= ipta_pkg::RESET_PC_VAL;
    end
  end

  assign CORE_REQ = req_r;
  assign TRAP_LEVEL_FLAG = tflag_r;
  assign RESET_REQ = rst_req_r;
  assign RESET_PC = rst_pc_r;

endmodule

`default_nettype wire

// file: test/core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------
// processor core stand-in
// ---------------------------------------------
module core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench controls
  input wire logic [3:0] base_lvl,
  input wire logic ack_en,
  input wire logic stall,
  // arbiter side
  input wire ipta_pkg::core_req_t req,
  output logic [3:0] cpu_lvl,
  output logic instr_done,
  output logic core_ack
);
  logic [3:0] trap_lvl_r;

  // a stalled core is mid-instruction, so traps must wait
  assign instr_done = !stall;
  // a running trap lifts the core level, top bit set
  assign cpu_lvl = trap_lvl_r[3] ? trap_lvl_r : base_lvl;

  // every trap vector counts as filled; the bench injects an unfilled one
  // one ack per request; a higher trap may cut in on a running one
  // the level test stops a stale request from being taken twice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_ack <= 1'b0;
      trap_lvl_r <= 4'h0;
    end else begin
      core_ack <= req.valid && req.trap && ack_en && !core_ack
        && (req.level > cpu_lvl);
      if (!ack_en) begin
        trap_lvl_r <= 4'h0;
      end else if (core_ack) begin
        trap_lvl_r <= req.level;
      end
    end
  end
endmodule

`default_nettype wire

// file: test/ipta_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------
// port checker
// ---------------------------------------------
module ipta_chk (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // causes
  input wire logic [ipta_pkg::NUM_TRAP-1:0] TRAP_EVENT,
  input wire logic VEC_ADDR_INVALID,
  input wire logic INSTR_DONE,
  input wire logic WDT_TIMEOUT,
  input wire logic UNINIT_W_PTR,
  input wire logic ILLEGAL_OP_EXEC,
  input wire logic ILLEGAL_OP_FLUSHED,
  input wire logic BROWNOUT,
  input wire logic [3:0] CPU_PRIORITY_LEVEL,
  // results
  input wire ipta_pkg::core_req_t CORE_REQ,
  input wire logic TRAP_LEVEL_FLAG,
  input wire logic RESET_REQ,
  input wire logic [23:0] RESET_PC
);
  // numbers that own a source
  localparam logic [63:0] LIVE = 64'h0000_0990_0087_FFFF;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  wire t_req = CORE_REQ.valid && CORE_REQ.trap;
  wire i_req = CORE_REQ.valid && !CORE_REQ.trap;
  wire [7:0] num = CORE_REQ.vector - 8'h08;

  // two trap sources at once escalate instead of being taken
  sequence multi_trap;
    $countones({TRAP_EVENT, VEC_ADDR_INVALID}) > 1;
  endsequence
  sequence one_cause;
    WDT_TIMEOUT || UNINIT_W_PTR || BROWNOUT || (ILLEGAL_OP_EXEC && !ILLEGAL_OP_FLUSHED);
  endsequence

  trap_flag_match_a: assert property (
    TRAP_LEVEL_FLAG == t_req) else $error("trap flag differs");
  trap_level_map_a: assert property (
    t_req |-> CORE_REQ.level == {1'b1, CORE_REQ.vector[2:0]} && CORE_REQ.vector[7:3] == 5'h00)
    else $error("trap level or vector wrong");
  irq_above_cpu_a: assert property (
    i_req |-> CORE_REQ.level > $past(CPU_PRIORITY_LEVEL) && CORE_REQ.level != 4'h0
      && !CORE_REQ.level[3]) else $error("interrupt level not above core");
  irq_vector_live_a: assert property (
    i_req |-> CORE_REQ.vector >= 8'h08 && CORE_REQ.vector <= 8'h3D && LIVE[num[5:0]])
    else $error("interrupt vector not a source");
  trap_boundary_a: assert property (
    t_req |-> $past(INSTR_DONE)) else $error("trap shown mid instruction");
  cause_reset_a: assert property (
    one_cause |=> RESET_REQ) else $error("reset cause lost");
  flushed_quiet_a: assert property (
    ILLEGAL_OP_EXEC && ILLEGAL_OP_FLUSHED && !WDT_TIMEOUT && !UNINIT_W_PTR && !BROWNOUT
      && $countones({TRAP_EVENT, VEC_ADDR_INVALID}) < 2 |=> !RESET_REQ)
    else $error("flushed opcode reset");
  lockout_reset_a: assert property (
    multi_trap |=> RESET_REQ) else $error("no lockout reset");
  reset_pc_zero_a: assert property (
    RESET_PC == 24'h000000) else $error("reset pc not zero");
endmodule

`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, INSTR_DONE, CORE_ACK, TRAP_LEVEL_FLAG, RESET_REQ;
  logic [53:0] SRC_EVENT = 54'h0;
  logic [7:0] TRAP_EVENT = 8'h00;
  logic VEC_ADDR_INVALID = 1'b0;
  logic [4:0] cf = 5'h00;
  logic [3:0] base_lvl = 4'h0;
  logic ack_en = 1'b0;
  logic stall = 1'b0;
  logic [3:0] CPU_PRIORITY_LEVEL;
  ipta_pkg::core_req_t CORE_REQ;
  logic [23:0] RESET_PC;
  logic [31:0] rdata_q;
  logic err_q;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  always #50 MCLK = ~MCLK;

  interrupt_priority_trap_arbiter DUT (
    .MCLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .SRC_EVENT, .TRAP_EVENT, .VEC_ADDR_INVALID, .INSTR_DONE,
    .WDT_TIMEOUT(cf[0]), .UNINIT_W_PTR(cf[1]), .ILLEGAL_OP_EXEC(cf[2]),
    .BROWNOUT(cf[3]), .ILLEGAL_OP_FLUSHED(cf[4]), .CPU_PRIORITY_LEVEL,
    .CORE_ACK, .CORE_REQ, .TRAP_LEVEL_FLAG, .RESET_REQ, .RESET_PC
  );

  core_model core (
    .clk(MCLK), .rst_n(RST_N), .base_lvl, .ack_en, .stall, .req(CORE_REQ),
    .cpu_lvl(CPU_PRIORITY_LEVEL), .instr_done(INSTR_DONE), .core_ack(CORE_ACK)
  );

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic end_of_test();
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hung wait must still reach the verdict
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    // only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    rdata_q = PRDATA;
    err_q = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata_q, exp);
  endtask

  // one-cycle pulses; returns just after the sampling edge
  task automatic pulse(input logic [53:0] ev, input logic [8:0] tv, input logic [4:0] c);
    @(posedge MCLK);
    SRC_EVENT <= ev;
    {VEC_ADDR_INVALID, TRAP_EVENT} <= tv;
    cf <= c;
    @(posedge MCLK);
    SRC_EVENT <= 54'h0;
    {VEC_ADDR_INVALID, TRAP_EVENT} <= 9'h000;
    cf <= 5'h00;
    #1;
  endtask

  task automatic lvl(input logic [3:0] l);
    @(posedge MCLK);
    base_lvl <= l;
    tick(2);
  endtask

  function automatic logic [31:0] rq(input logic t, input logic [3:0] l, input logic [7:0] v);
    return {18'h0, 1'b1, t, l, v};
  endfunction

  function automatic logic live(input int n);
    return n <= 18 || n == 23 || n == 36 || n == 39 || n == 40 || n == 43;
  endfunction

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_regs();
    rd(8'h00, 32'h0);
    rd(8'h48, 32'h0);
    rd(8'h44, 32'h0);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_7777);
    apb(1'b0, 8'h60, 32'h0);
    chk(err_q, 1'b1);
    chk(RESET_PC, 24'h000000);
  endtask

  task automatic t_table();
    for (int k = 0; k < 14; k++) begin
      wr(8'(4 * k), 32'h1111);
    end
    wr(8'h48, 32'hFFFF_FFFF);
    wr(8'h4C, 32'h003F_FFFF);
    for (int n = 0; n < 54; n++) begin
      pulse(54'h1 << n, 9'h000, 5'h00);
      tick(1);
      chk(CORE_REQ.valid, live(n));
      if (live(n)) chk(CORE_REQ, rq(1'b0, 4'h1, 8'(n + 8)));
      wr(n < 32 ? 8'h40 : 8'h44, 32'h1 << (n % 32));
    end
  endtask

  task automatic t_prio();
    wr(8'h48, 32'h0);
    pulse(54'h8, 9'h000, 5'h00);
    tick(1);
    chk(CORE_REQ.valid, 1'b0);
    rd(8'h40, 32'h8);
    wr(8'h00, 32'h0111);
    wr(8'h48, 32'hFFFF_FFFF);
    tick(2);
    chk(CORE_REQ.valid, 1'b0);
    wr(8'h40, 32'h8);
    wr(8'h00, 32'h5111);
    wr(8'h14, 32'h5111);
    pulse(54'h80_0008, 9'h000, 5'h00);
    tick(1);
    chk(CORE_REQ, rq(1'b0, 4'h5, 8'h0B));
    wr(8'h24, 32'h7111);
    pulse(54'h80_0000_0000, 9'h000, 5'h00);
    tick(1);
    chk(CORE_REQ, rq(1'b0, 4'h7, 8'h2F));
    lvl(4'h7);
    chk(CORE_REQ.valid, 1'b0);
    wr(8'h44, 32'h80);
    lvl(4'h5);
    chk(CORE_REQ.valid, 1'b0);
    lvl(4'h4);
    chk(CORE_REQ, rq(1'b0, 4'h5, 8'h0B));
  endtask

  task automatic t_trap();
    lvl(4'h7);
    @(posedge MCLK);
    stall <= 1'b1;
    pulse(54'h0, 9'h004, 5'h00);
    tick(3);
    chk(CORE_REQ.valid, 1'b0);
    @(posedge MCLK);
    stall <= 1'b0;
    tick(2);
    chk(CORE_REQ, rq(1'b1, 4'hA, 8'h02));
    chk(TRAP_LEVEL_FLAG, 1'b1);
    rd(8'h50, 32'h0004_3A02);
    @(posedge MCLK);
    ack_en <= 1'b1;
    tick(5);
    chk(CORE_REQ.valid, 1'b0);
    pulse(54'h0, 9'h100, 5'h00);
    tick(1);
    chk(CORE_REQ, rq(1'b1, 4'hC, 8'h04));
    tick(3);
    pulse(54'h0, 9'h020, 5'h00);
    tick(1);
    chk(CORE_REQ, rq(1'b1, 4'hD, 8'h05));
    tick(3);
    @(posedge MCLK);
    ack_en <= 1'b0;
    tick(2);
  endtask

  task automatic t_causes();
    for (int i = 0; i < 4; i++) begin
      pulse(54'h0, 9'h000, 5'(1 << i));
      chk(RESET_REQ, 1'b1);
      rd(8'h54, 32'((2 << i) - 1));
    end
    pulse(54'h0, 9'h000, 5'h14);
    chk(RESET_REQ, 1'b0);
    pulse(54'h0, 9'h003, 5'h00);
    chk(RESET_REQ, 1'b1);
    tick(1);
    chk(CORE_REQ.valid, 1'b0);
    rd(8'h54, 32'h1F);
    wr(8'h54, 32'h1F);
    rd(8'h54, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge MCLK);
    RST_N <= 1'b1;
    t_regs();
    t_table();
    t_prio();
    t_trap();
    t_causes();
    end_of_test();
  end
endmodule

bind interrupt_priority_trap_arbiter ipta_chk chk_i (
  .MCLK, .RST_N, .TRAP_EVENT, .VEC_ADDR_INVALID, .INSTR_DONE, .WDT_TIMEOUT,
  .UNINIT_W_PTR, .ILLEGAL_OP_EXEC, .ILLEGAL_OP_FLUSHED, .BROWNOUT,
  .CPU_PRIORITY_LEVEL, .CORE_REQ, .TRAP_LEVEL_FLAG, .RESET_REQ, .RESET_PC
);

`default_nettype wire
